//--- logic/uart_rx_buffer.v
// two-entry receive buffer, oldest byte at the head
`timescale 1ns/1ps
`include "uart_status_data_consts.vh"

module uart_rx_buffer
(
  input  wire       clk_in,
  input  wire       arst_n_in,
  input  wire       push_in,
  input  wire [7:0] push_data_in,
  input  wire       pop_in,
  output wire [7:0] head_out,
  output wire [1:0] count_out,
  output wire       overrun_out
);

  reg  [7:0] oldest_q;
  reg  [7:0] newest_q;
  reg  [1:0] count_q;
  wire       full;
  wire       do_pop;
  wire       do_push;

  assign full        = (count_q == `RX_DEPTH);
  assign do_pop      = pop_in && (count_q != 2'h0);
  // a pop in the same cycle frees room, so a full buffer still accepts
  assign do_push     = push_in && (!full || do_pop);
  assign overrun_out = push_in && full && !do_pop;
  assign head_out    = oldest_q;
  assign count_out   = count_q;

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      oldest_q <= `RST_RX_DATA;
      newest_q <= `RST_RX_DATA;
      count_q  <= 2'h0;
    end
    else if (do_pop && do_push)
    begin
      if (count_q == `RX_DEPTH)
      begin
        oldest_q <= newest_q;
        newest_q <= push_data_in;
      end
      else
      begin
        oldest_q <= push_data_in;
      end
    end
    else if (do_pop)
    begin
      oldest_q <= newest_q;
      count_q  <= count_q - 2'h1;
    end
    else if (do_push)
    begin
      if (count_q == 2'h0)
      begin
        oldest_q <= push_data_in;
      end
      else
      begin
        newest_q <= push_data_in;
      end
      count_q <= count_q + 2'h1;
    end
  end

endmodule

//--- logic/uart_status_data_consts.vh
// register indices, field positions and reset values of the serial port
`ifndef UART_STATUS_DATA_CONSTS_VH
`define UART_STATUS_DATA_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_SERIAL_STATUS        16'h4100
`define IDX_SERIAL_TRANSMIT_DATA 16'h4101
`define IDX_SERIAL_RECEIVE_DATA  16'h4102
`define IDX_SERIAL_IRQ_MASK      16'h4108
`define IDX_SERIAL_CONFIG        16'h4109

// ----------------------------------------------------------------------
// serial_status bit positions
// ----------------------------------------------------------------------
`define BIT_TX_COMPLETE          7
`define BIT_FRAMING_FAULT        6
`define BIT_PARITY_FAULT         5
`define BIT_OVERRUN_FAULT        4
`define BIT_SECOND_RX_BYTE       3
`define BIT_TX_SHIFTER_BUSY      2
`define BIT_RX_READY             1
`define BIT_TX_BUFFER_EMPTY      0

// serial_config bit positions
`define BIT_CHAR_8BIT            0

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define RST_TX_DATA              8'h00
`define RST_RX_DATA              8'h00
`define RST_IRQ_MASK             8'h00
`define RST_CHAR_8BIT            1'b1
`define MASK_7BIT_CHAR           8'h7F
`define RX_DEPTH                 2'h2

`endif

//--- logic/uart_status_data_regs.v
// status, transmit-data and receive-data registers of a serial port
`timescale 1ns/1ps
`include "uart_status_data_consts.vh"

module uart_status_data_regs
(
  input  wire        clk_in,
  input  wire        arst_n_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [17:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // transmit shifter side
  input  wire        tx_take_in,
  input  wire        tx_done_in,
  input  wire        tx_shifter_busy_in,
  output wire [7:0]  tx_data_out,
  output wire        tx_data_valid_out,
  // receive shifter side
  input  wire        rx_byte_valid_in,
  input  wire [7:0]  rx_byte_in,
  input  wire        rx_framing_err_in,
  input  wire        rx_parity_err_in,
  // configuration and interrupt
  output wire        char_8bit_out,
  output wire        irq_out
);

  // --------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------
  // registers are word aligned: byte address is index times four
  function reg_hit;
    input [17:0] addr;
    input [15:0] index;
    begin
      reg_hit = (addr == {index, 2'b00});
    end
  endfunction

  function [7:0] char_trim;
    input [7:0] value;
    input       eight_bit;
    begin
      char_trim = eight_bit ? value : (value & `MASK_7BIT_CHAR);
    end
  endfunction

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg         rd_had_byte_q;
  reg         tx_complete_flag_q;
  reg         framing_fault_flag_q;
  reg         parity_fault_flag_q;
  reg         overrun_fault_flag_q;
  reg  [7:0]  tx_data_q;
  reg         tx_full_q;
  reg  [7:0]  irq_mask_q;
  reg         char_8bit_q;
  reg         irq_q;
  reg         tx_busy_q;

  wire        access;
  wire        capture;
  wire        wr_fire;
  wire        rd_fire;
  wire        hit_status;
  wire        hit_txd;
  wire        hit_rxd;
  wire        hit_mask;
  wire        hit_config;
  wire        mapped;
  wire [7:0]  wbyte;
  wire [7:0]  rx_head;
  wire [1:0]  rx_count;
  wire        rx_overrun;
  wire        rx_pop;
  wire        clr_tx_complete;
  wire        clr_framing;
  wire        clr_parity;
  wire        clr_overrun;
  wire        tx_write;
  wire [7:0]  status_byte;
  reg  [7:0]  read_byte;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  assign access     = psel_in && penable_in;
  assign capture    = access && !pready_q;
  assign wr_fire    = access && pready_q && pwrite_in;
  assign rd_fire    = access && pready_q && !pwrite_in;
  assign hit_status = reg_hit(paddr_in, `IDX_SERIAL_STATUS);
  assign hit_txd    = reg_hit(paddr_in, `IDX_SERIAL_TRANSMIT_DATA);
  assign hit_rxd    = reg_hit(paddr_in, `IDX_SERIAL_RECEIVE_DATA);
  assign hit_mask   = reg_hit(paddr_in, `IDX_SERIAL_IRQ_MASK);
  assign hit_config = reg_hit(paddr_in, `IDX_SERIAL_CONFIG);
  assign mapped     = hit_status || hit_txd || hit_rxd || hit_mask ||
                      hit_config;
  // only the low byte of a write word is used
  assign wbyte      = pwdata_in[7:0];

  // --------------------------------------------------------------------
  // status assembly
  // --------------------------------------------------------------------
  // D3..D0 follow live state; only D7..D4 are sticky
  assign status_byte[`BIT_TX_COMPLETE]     = tx_complete_flag_q;
  assign status_byte[`BIT_FRAMING_FAULT]   = framing_fault_flag_q;
  assign status_byte[`BIT_PARITY_FAULT]    = parity_fault_flag_q;
  assign status_byte[`BIT_OVERRUN_FAULT]   = overrun_fault_flag_q;
  assign status_byte[`BIT_SECOND_RX_BYTE]  = (rx_count == `RX_DEPTH);
  assign status_byte[`BIT_TX_SHIFTER_BUSY] = tx_busy_q;
  assign status_byte[`BIT_RX_READY]        = (rx_count != 2'h0);
  assign status_byte[`BIT_TX_BUFFER_EMPTY] = !tx_full_q;

  always @*
  begin
    read_byte = 8'h00;
    if (hit_status)
    begin
      read_byte = status_byte;
    end
    else if (hit_txd)
    begin
      read_byte = tx_data_q;
    end
    else if (hit_rxd)
    begin
      read_byte = rx_head;
    end
    else if (hit_mask)
    begin
      read_byte = irq_mask_q;
    end
    else if (hit_config)
    begin
      read_byte = {7'h00, char_8bit_q};
    end
  end

  // --------------------------------------------------------------------
  // bus answer
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prdata_q      <= 32'h0000_0000;
      pready_q      <= 1'b0;
      pslverr_q     <= 1'b0;
      rd_had_byte_q <= 1'b0;
    end
    else
    begin
      pready_q <= capture;
      if (capture)
      begin
        // writes and unmapped reads put zero on the data bus
        prdata_q      <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_byte};
        pslverr_q     <= !mapped;
        // only a byte that was actually returned may be popped
        rd_had_byte_q <= (rx_count != 2'h0);
      end
      else
      begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // receive buffer
  // --------------------------------------------------------------------
  // an empty read pops nothing, so a byte arriving late is kept
  assign rx_pop = rd_fire && hit_rxd && rd_had_byte_q;

  // bytes are trimmed on the way in, so reads need no mask
  uart_rx_buffer u_rx_buffer
  (
    .clk_in       (clk_in),
    .arst_n_in    (arst_n_in),
    .push_in      (rx_byte_valid_in),
    .push_data_in (char_trim(rx_byte_in, char_8bit_q)),
    .pop_in       (rx_pop),
    .head_out     (rx_head),
    .count_out    (rx_count),
    .overrun_out  (rx_overrun)
  );

  // --------------------------------------------------------------------
  // sticky flags, set wins over a write-one clear
  // --------------------------------------------------------------------
  // framing and parity set even when the byte itself is dropped
  assign clr_tx_complete = wr_fire && hit_status && wbyte[`BIT_TX_COMPLETE];
  assign clr_framing     = wr_fire && hit_status && wbyte[`BIT_FRAMING_FAULT];
  assign clr_parity      = wr_fire && hit_status && wbyte[`BIT_PARITY_FAULT];
  assign clr_overrun     = wr_fire && hit_status && wbyte[`BIT_OVERRUN_FAULT];

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tx_complete_flag_q   <= 1'b0;
      framing_fault_flag_q <= 1'b0;
      parity_fault_flag_q  <= 1'b0;
      overrun_fault_flag_q <= 1'b0;
    end
    else
    begin
      tx_complete_flag_q   <= (tx_complete_flag_q & ~clr_tx_complete) |
                              tx_done_in;
      framing_fault_flag_q <= (framing_fault_flag_q & ~clr_framing) |
                              (rx_byte_valid_in & rx_framing_err_in);
      parity_fault_flag_q  <= (parity_fault_flag_q & ~clr_parity) |
                              (rx_byte_valid_in & rx_parity_err_in);
      overrun_fault_flag_q <= (overrun_fault_flag_q & ~clr_overrun) |
                              rx_overrun;
    end
  end

  // --------------------------------------------------------------------
  // transmit data buffer
  // --------------------------------------------------------------------
  // a write while full overwrites the pending byte
  assign tx_write = wr_fire && hit_txd;

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tx_data_q <= `RST_TX_DATA;
      tx_full_q <= 1'b0;
    end
    else
    begin
      if (tx_write)
      begin
        tx_data_q <= char_trim(wbyte, char_8bit_q);
      end
      // a new write in the take cycle keeps the buffer full
      tx_full_q <= tx_write | (tx_full_q & ~tx_take_in);
    end
  end

  // --------------------------------------------------------------------
  // mask, config and interrupt
  // --------------------------------------------------------------------
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_mask_q  <= `RST_IRQ_MASK;
      char_8bit_q <= `RST_CHAR_8BIT;
      irq_q       <= 1'b0;
      tx_busy_q   <= 1'b0;
    end
    else
    begin
      if (wr_fire && hit_mask)
      begin
        irq_mask_q <= wbyte;
      end
      // char length applies to bytes stored later, not held ones
      if (wr_fire && hit_config)
      begin
        char_8bit_q <= wbyte[`BIT_CHAR_8BIT];
      end
      // registered, so irq lags the status by one cycle
      irq_q     <= |(status_byte & irq_mask_q);
      tx_busy_q <= tx_shifter_busy_in;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // outputs come straight from flops, no logic after them
  assign prdata_out        = prdata_q;
  assign pready_out        = pready_q;
  assign pslverr_out       = pslverr_q;
  assign tx_data_out       = tx_data_q;
  assign tx_data_valid_out = tx_full_q;
  assign char_8bit_out     = char_8bit_q;
  assign irq_out           = irq_q;

endmodule

//--- sim/tb_uart_status_data_regs.sv
// self-checking bench for the serial status and data registers
`timescale 1ns/1ps
module tb_uart_status_data_regs;
  localparam logic [17:0] A_ST = 18'h10400;
  localparam logic [17:0] A_TX = 18'h10404;
  localparam logic [17:0] A_RX = 18'h10408;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b1;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000, prdata_out, r;
  logic        pready_out, pslverr_out, e, eight = 1'b1;
  logic        take, done, busy, tx_valid, char8, irq;
  logic        rx_v = 1'b0, rx_fe = 1'b0, rx_pe = 1'b0;
  logic [7:0]  rx_b = 8'h00, tx_data, got, v, w;
  int          seed = 74, n_mismatch = 0, compares = 0, i;

  always #10 clk_in = ~clk_in;

  uart_status_data_regs uart_status_data_regs_i (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .tx_take_in(take), .tx_done_in(done),
    .tx_shifter_busy_in(busy), .tx_data_out(tx_data),
    .tx_data_valid_out(tx_valid), .rx_byte_valid_in(rx_v),
    .rx_byte_in(rx_b), .rx_framing_err_in(rx_fe),
    .rx_parity_err_in(rx_pe), .char_8bit_out(char8), .irq_out(irq));
  uart_far_end uart_far_end_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .slow_in(slow), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_take_out(take), .tx_done_out(done), .busy_out(busy),
    .got_out(got));

  task close_out;
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    compares++;
    if (got_v !== exp_v)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  function automatic logic [31:0] ch(input logic [7:0] b);
    return {24'h000000, eight ? b : b & 8'h7F};
  endfunction

  // request held from setup until ready is sampled high
  task apb(input logic wr_en, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    r = prdata_out;
    e = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_mismatch++;
      close_out;
    end
  endtask

  task rc(input logic [17:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(r & m, x);
  endtask

  task poll(input logic [31:0] m, input logic [31:0] x);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_ST, 32'h00000000);
      n++;
    end
    while ((r & m) !== x && n < 60);
    if (n >= 60)
    begin
      n_mismatch++;
      close_out;
    end
  endtask

  task rxs(input logic [7:0] b, input logic fe, input logic pe);
    @(posedge clk_in);
    rx_v <= 1'b1;
    rx_b <= b;
    rx_fe <= fe;
    rx_pe <= pe;
    @(posedge clk_in);
    rx_v <= 1'b0;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rc(A_ST, 32'hFFFFFFFF, 32'h01);
    rc(A_RX, 32'hFFFFFFFF, 32'h00);
    apb(1'b0, 18'h10410, 32'h00000000);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 18'h10420, 32'h80);
    for (i = 0; i < 2; i++)
    begin
      eight = (i == 0);
      slow <= eight;
      apb(1'b1, 18'h10424, {31'h0, eight});
      v = 8'($random(seed));
      w = 8'($random(seed));
      apb(1'b1, A_TX, {24'h0, v});
      chk({31'h0, char8}, {31'h0, eight});
      apb(1'b1, A_TX, {24'h0, w});
      rc(A_TX, 32'hFFFFFFFF, ch(w));
      if (slow)
        rc(A_ST, 32'h05, 32'h04);
      poll(32'h85, 32'h81);
      chk({24'h0, got}, ch(w));
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, A_ST, 32'h7F);
      rc(A_ST, 32'hFF, 32'h81);
      apb(1'b1, A_ST, 32'h80);
      rc(A_ST, 32'hFF, 32'h01);
      chk({31'h0, irq}, 32'h0);
      rxs(v, 1'b0, 1'b0);
      rxs(w, 1'b0, 1'b0);
      rc(A_ST, 32'h0A, 32'h0A);
      rc(A_RX, 32'hFF, ch(v));
      rc(A_ST, 32'h0A, 32'h02);
      rc(A_RX, 32'hFF, ch(w));
      rc(A_ST, 32'h0A, 32'h00);
      rxs(w, 1'b0, 1'b0);
      rxs(v, 1'b0, 1'b1);
      rxs(8'h55, 1'b1, 1'b0); // third byte has no room
      rc(A_ST, 32'h7A, 32'h7A);
      apb(1'b1, A_ST, 32'h70);
      rc(A_RX, 32'hFF, ch(w));
      rc(A_RX, 32'hFF, ch(v));
      rc(A_ST, 32'h7A, 32'h00);
    end
    close_out;
  end
endmodule

//--- sim/uart_far_end.sv
// far-side shifter model: takes buffered bytes, reports completion
`timescale 1ns/1ps
module uart_far_end (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_take_out,
  output logic            tx_done_out,
  output logic            busy_out,
  output logic [7:0]      got_out
);
  logic [4:0] cnt_q;
  // slow mode keeps a second byte waiting in the buffer
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      tx_take_out <= 1'b0;
      tx_done_out <= 1'b0;
      busy_out <= 1'b0;
      got_out <= 8'h00;
      cnt_q <= 5'h00;
    end
    else
    begin
      tx_take_out <= 1'b0;
      tx_done_out <= 1'b0;
      if (busy_out)
      begin
        cnt_q <= cnt_q - 5'h01;
        busy_out <= cnt_q != 5'h00;
        tx_done_out <= cnt_q == 5'h00;
      end
      else if (tx_valid_in)
      begin
        tx_take_out <= 1'b1;
        got_out <= tx_data_in;
        busy_out <= 1'b1;
        cnt_q <= slow_in ? 5'h14 : 5'h02;
      end
    end
endmodule

//--- sim/uart_regs_monitor.sv
// port-level assertions for the serial status and data registers
`timescale 1ns/1ps
module uart_regs_monitor (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [17:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        tx_take_in,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_data_valid_out,
  input wire logic        char_8bit_out
);
  logic wr_tx;
  assign wr_tx = psel_in && penable_in && pready_out && pwrite_in
    && paddr_in == 18'h10404;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  AST_PREADY_WAIT: assert property (psel_in && $rose(penable_in)
    |=> pready_out) else $error("access not answered in one wait");
  AST_PREADY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  AST_SLVERR_PAIR: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_RDATA_TOP: assert property (pready_out
    |-> prdata_out[31:8] == 24'h000000) else $error("upper read bits set");
  AST_TX_SET: assert property (wr_tx |=> tx_data_valid_out)
    else $error("buffer not full after write");
  AST_TX_HOLD: assert property (tx_data_valid_out && !tx_take_in
    |=> tx_data_valid_out) else $error("buffered byte lost");
  AST_TX_TAKE: assert property (tx_take_in && !wr_tx
    |=> !tx_data_valid_out) else $error("buffer not emptied by take");
  AST_TX_CHAR: assert property (wr_tx |=> tx_data_out ==
    ($past(pwdata_in[7:0]) & ($past(char_8bit_out) ? 8'hFF : 8'h7F)))
    else $error("transmit byte not aligned or masked");
  cover property (wr_tx);
  cover property (pslverr_out);
  cover property (tx_take_in && tx_data_valid_out);
endmodule

bind uart_status_data_regs uart_regs_monitor uart_regs_monitor_i (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .tx_take_in(tx_take_in), .tx_data_out(tx_data_out),
  .tx_data_valid_out(tx_data_valid_out), .char_8bit_out(char_8bit_out));
